// ===== common/scp_pkg.sv
// package: constants for the serial configuration port and its register map
package scp_pkg;

    // ****************************************************************
    // register map, byte offsets as seen on the serial address
    // ****************************************************************
    localparam int REG_NUM = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int IDX_W = 5;
    localparam logic [7:0] OFS_PART_VERSION_CODE = 8'h00;
    localparam logic [7:0] OFS_IO_POLARITY = 8'h04;
    localparam logic [7:0] OFS_TX_RX_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ADC_CAL_POSITIVE_STEP = 8'h0c;
    localparam logic [7:0] OFS_ADC_CAL_NEGATIVE_STEP = 8'h10;
    localparam logic [7:0] OFS_CCA_ANTENNA_CONTROL = 8'h14;
    localparam logic [7:0] OFS_PREAMBLE_LENGTH = 8'h18;
    localparam logic [7:0] OFS_SCRAMBLER_TAPS = 8'h1c;
    localparam logic [7:0] OFS_ACQ_QUALITY1_THRESH_HIGH = 8'h20;
    localparam logic [7:0] OFS_ACQ_QUALITY1_THRESH_LOW = 8'h24;
    localparam logic [7:0] OFS_ACQ_QUALITY2_THRESH_HIGH = 8'h28;
    localparam logic [7:0] OFS_ACQ_QUALITY2_THRESH_LOW = 8'h2c;
    localparam logic [7:0] OFS_CCA_QUALITY_THRESH_HIGH = 8'h30;
    localparam logic [7:0] OFS_CCA_QUALITY_THRESH_LOW = 8'h34;
    localparam logic [7:0] OFS_ENERGY_DETECT_THRESH = 8'h38;
    localparam logic [7:0] OFS_START_DELIM_TIMER = 8'h3c;
    localparam logic [7:0] OFS_SIGNAL_CODE_BPSK_CHIP = 8'h40;
    localparam logic [7:0] OFS_SIGNAL_CODE_QPSK_CHIP = 8'h44;
    localparam logic [7:0] OFS_SIGNAL_CODE_BPSK_WALSH = 8'h48;
    localparam logic [7:0] OFS_SIGNAL_CODE_QPSK_WALSH = 8'h4c;
    localparam logic [7:0] OFS_TX_SIGNAL_FIELD = 8'h50;
    localparam logic [7:0] OFS_TX_SERVICE_FIELD = 8'h54;
    localparam logic [7:0] OFS_TX_LENGTH_HIGH = 8'h58;
    localparam logic [7:0] OFS_TX_LENGTH_LOW = 8'h5c;
    localparam logic [7:0] OFS_RX_STATUS = 8'h60;
    localparam logic [7:0] OFS_RX_SERVICE_FIELD = 8'h64;
    localparam logic [7:0] OFS_RX_LENGTH_HIGH = 8'h68;
    localparam logic [7:0] OFS_RX_LENGTH_LOW = 8'h6c;
    localparam logic [7:0] OFS_PROBE_SELECT = 8'h70;
    localparam logic [7:0] OFS_PROBE_MONITOR = 8'h74;
    localparam logic [7:0] OFS_FACTORY_TEST_1 = 8'h78;
    localparam logic [7:0] OFS_FACTORY_TEST_2 = 8'h7c;

    // register index = address bits 6:2, the two low bits are ignored
    localparam int IDX_LSB = 2;
    localparam int ADDR_RANGE_BIT = 7;
    localparam logic [IDX_W-1:0] IDX_PART_VERSION_CODE = OFS_PART_VERSION_CODE[6:2];
    localparam logic [IDX_W-1:0] IDX_TX_RX_CONTROL = OFS_TX_RX_CONTROL[6:2];
    localparam logic [IDX_W-1:0] IDX_RX_STATUS = OFS_RX_STATUS[6:2];
    localparam logic [IDX_W-1:0] IDX_RX_SERVICE_FIELD = OFS_RX_SERVICE_FIELD[6:2];
    localparam logic [IDX_W-1:0] IDX_RX_LENGTH_HIGH = OFS_RX_LENGTH_HIGH[6:2];
    localparam logic [IDX_W-1:0] IDX_RX_LENGTH_LOW = OFS_RX_LENGTH_LOW[6:2];
    localparam logic [IDX_W-1:0] IDX_PROBE_SELECT = OFS_PROBE_SELECT[6:2];
    localparam logic [IDX_W-1:0] IDX_PROBE_MONITOR = OFS_PROBE_MONITOR[6:2];

    // one bit per register, set where software may not write
    localparam logic [REG_NUM-1:0] RO_MASK = 32'h2f00_0001;
    // transceiver clock divide select: 0 divides by 2, 1 divides by 4
    localparam int DIV_SEL_BIT = 0;
    localparam logic [7:0] CFG_RST = 8'h00;

    // ****************************************************************
    // synchroniser lanes and timing
    // ****************************************************************
    localparam int SYN_W = 6;
    localparam int SYN_SCLK = 0;
    localparam int SYN_CS_N = 1;
    localparam int SYN_RW = 2;
    localparam int SYN_SD = 3;
    localparam int SYN_MRST_N = 4;
    localparam int SYN_RE = 5;
    localparam logic [SYN_W-1:0] SYN_RST = 6'h12;
    localparam int RE_HOLD_MCLK = 2;
    localparam logic [1:0] RE_HOLD_CYC = 2'(RE_HOLD_MCLK);
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0] {
        SCP_IDLE = 2'b00,
        SCP_ADDR = 2'b01,
        SCP_WDATA = 2'b10,
        SCP_RDATA = 2'b11
    } scp_state_t;

endpackage

// ===== common/scp_sync_if.sv
// interface: raw pin levels into the synchroniser and clean levels out
`timescale 1ns/10ps
interface scp_sync_if;
    import scp_pkg::*;
    logic [SYN_W-1:0] raw;
    logic [SYN_W-1:0] clean;
    modport src (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

// ===== logic/scp_serial_regs.sv
// module: serial configuration port, register map, master reset and clocks
`timescale 1ns/10ps
module scp_serial_regs
    import scp_pkg::*;
#(
    // identity byte, value arbitrary
    parameter logic [7:0] PART_VERSION = 8'h5a
) (
    // system clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // serial port pins
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic RW_I,
    input wire logic SD_I,
    output logic SD_O,
    output logic SD_OE_O,
    // master reset and receive enable pins
    input wire logic MRST_N_I,
    input wire logic RECEIVE_ENABLE_I,
    // transceiver control
    output logic STANDBY_O,
    output logic TXRX_EN_O,
    output logic TRX_CLK_EN_O,
    // receive status for read-only registers
    input wire logic [7:0] RX_STATUS_I,
    input wire logic [7:0] RX_SERVICE_I,
    input wire logic [7:0] RX_LEN_HIGH_I,
    input wire logic [7:0] RX_LEN_LOW_I,
    // configuration contents, register n in bits 8n+7:8n
    output logic [REG_NUM*DATA_W-1:0] CFG_REGS_O,
    // probe port
    output logic PROBE_CLK_O,
    output logic [7:0] PROBE_DATA_O
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        scp_state_t state;
        logic [2:0] bit_cnt;
        logic [ADDR_W-1:0] addr_sh;
        logic [DATA_W-1:0] wr_sh;
        logic [DATA_W-1:0] rd_sh;
        logic sclk_prev;
        logic sd_out;
        logic sd_oe;
        logic [REG_NUM-1:0][DATA_W-1:0] regs;
        logic standby;
        logic txrx_en;
        logic [1:0] re_cnt;
        logic [1:0] div_cnt;
        logic trx_en;
        logic probe_clk;
        logic [DATA_W-1:0] probe_data;
    } scp_core_t;

    scp_core_t q, d;
    scp_sync_if syn ();
    logic [REG_NUM-1:0][DATA_W-1:0] rd_view;
    logic sclk_rise;
    logic [ADDR_W-1:0] addr_next;
    logic [IDX_W-1:0] addr_idx;
    logic addr_mapped;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    assign syn.raw = {RECEIVE_ENABLE_I, MRST_N_I, SD_I, RW_I, CS_N_I, SCLK_I};

    scp_sync u_sync (
        .clk_i (CLK_SYS_I),
        .nrst_i (NRST_I),
        .pins (syn)
    );

    // ****************************************************************
    // read view: stored bytes with read-only bytes overlaid
    // ****************************************************************
    always_comb begin
        rd_view = q.regs;
        rd_view[IDX_PART_VERSION_CODE] = PART_VERSION;
        rd_view[IDX_RX_STATUS] = RX_STATUS_I;
        rd_view[IDX_RX_SERVICE_FIELD] = RX_SERVICE_I;
        rd_view[IDX_RX_LENGTH_HIGH] = RX_LEN_HIGH_I;
        rd_view[IDX_RX_LENGTH_LOW] = RX_LEN_LOW_I;
        rd_view[IDX_PROBE_MONITOR] = q.probe_data;
    end

    // edge found only from synchronised levels, never the first stage
    assign sclk_rise = syn.clean[SYN_SCLK] & ~q.sclk_prev;
    assign addr_next = {q.addr_sh[ADDR_W-2:0], syn.clean[SYN_SD]};
    assign addr_idx = addr_next[IDX_LSB+IDX_W-1:IDX_LSB];
    assign addr_mapped = ~addr_next[ADDR_RANGE_BIT];

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        d = q;
        d.sclk_prev = syn.clean[SYN_SCLK];

        // serial engine; a deselect abandons any partial transfer
        if (syn.clean[SYN_CS_N]) begin
            d.state = SCP_IDLE;
            d.bit_cnt = 3'h0;
            d.sd_oe = 1'b0;
        end else if (sclk_rise) begin
            unique case (q.state)
                SCP_IDLE: begin
                    d.addr_sh = addr_next;
                    d.bit_cnt = 3'h1;
                    d.state = SCP_ADDR;
                end
                SCP_ADDR: begin
                    d.addr_sh = addr_next;
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    // data follows the address with no gap
                    if (q.bit_cnt == BIT_LAST) begin
                        if (syn.clean[SYN_RW]) begin
                            // unmapped addresses read as zero
                            d.rd_sh = addr_mapped ? rd_view[addr_idx] : 8'h00;
                            d.sd_out = d.rd_sh[DATA_W-1];
                            d.sd_oe = 1'b1;
                            d.state = SCP_RDATA;
                        end else begin
                            d.state = SCP_WDATA;
                        end
                    end
                end
                SCP_WDATA: begin
                    d.wr_sh = {q.wr_sh[DATA_W-2:0], syn.clean[SYN_SD]};
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    if (q.bit_cnt == BIT_LAST) begin
                        if (!q.addr_sh[ADDR_RANGE_BIT] && !RO_MASK[q.addr_sh[IDX_LSB+IDX_W-1:IDX_LSB]]) begin
                            d.regs[q.addr_sh[IDX_LSB+IDX_W-1:IDX_LSB]] = d.wr_sh;
                        end
                        d.state = SCP_IDLE;
                    end
                end
                SCP_RDATA: begin
                    // launch the next bit on each rising edge
                    d.rd_sh = {q.rd_sh[DATA_W-2:0], 1'b0};
                    d.sd_out = q.rd_sh[DATA_W-2];
                    d.bit_cnt = q.bit_cnt + 3'h1;
                    if (q.bit_cnt == BIT_LAST) begin
                        d.sd_oe = 1'b0;
                        d.state = SCP_IDLE;
                    end
                end
            endcase
        end

        // master reset leaves register contents alone on purpose
        d.standby = ~syn.clean[SYN_MRST_N];
        if (!syn.clean[SYN_MRST_N]) begin
            d.txrx_en = 1'b0;
            d.re_cnt = 2'h0;
        end else if (!q.txrx_en) begin
            // receive enable must stay high for the whole hold count
            if (syn.clean[SYN_RE]) begin
                if (q.re_cnt == RE_HOLD_CYC - 2'h1) begin
                    d.txrx_en = 1'b1;
                end else begin
                    d.re_cnt = q.re_cnt + 2'h1;
                end
            end else begin
                d.re_cnt = 2'h0;
            end
        end

        // transceiver clock enable: one pulse per 2 or 4 master cycles
        d.div_cnt = q.div_cnt + 2'h1;
        if (q.regs[IDX_TX_RX_CONTROL][DIV_SEL_BIT]) begin
            d.trx_en = (q.div_cnt == DIV4_LAST);
        end else begin
            d.trx_en = q.div_cnt[0];
        end

        // probe data moves on the falling probe clock, stable at its rise
        if (q.trx_en) begin
            d.probe_clk = ~q.probe_clk;
            if (q.probe_clk) begin
                d.probe_data = rd_view[q.regs[IDX_PROBE_SELECT][IDX_W-1:0]];
            end
        end
    end

    // ****************************************************************
    // registers; system reset clears, master reset does not
    // ****************************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            q <= '0;
            q.standby <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign SD_O = q.sd_out;
    assign SD_OE_O = q.sd_oe;
    assign STANDBY_O = q.standby;
    assign TXRX_EN_O = q.txrx_en;
    assign TRX_CLK_EN_O = q.trx_en;
    assign CFG_REGS_O = q.regs;
    assign PROBE_CLK_O = q.probe_clk;
    assign PROBE_DATA_O = q.probe_data;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_wr_last;
        !syn.clean[SYN_CS_N] && sclk_rise && q.state == SCP_WDATA && q.bit_cnt == BIT_LAST;
    endsequence

    sequence s_addr_read;
        !syn.clean[SYN_CS_N] && sclk_rise && q.state == SCP_ADDR && q.bit_cnt == BIT_LAST
            && syn.clean[SYN_RW];
    endsequence

    property p_deselect_idle;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        syn.clean[SYN_CS_N] |=> q.state == SCP_IDLE && !SD_OE_O;
    endproperty
    a_deselect_idle:
    assert property (p_deselect_idle) else $error("port not idle after deselect");

    property p_write_lands;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        s_wr_last ##0 (!q.addr_sh[ADDR_RANGE_BIT] && !RO_MASK[q.addr_sh[6:2]])
            |=> q.regs[$past(q.addr_sh[6:2])] == $past(d.wr_sh);
    endproperty
    a_write_lands:
    assert property (p_write_lands) else $error("write data not stored");

    property p_ro_kept;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        s_wr_last ##0 RO_MASK[q.addr_sh[6:2]] |=> $stable(q.regs);
    endproperty
    a_ro_kept:
    assert property (p_ro_kept) else $error("read-only register written");

    property p_read_drive;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        s_addr_read |=> SD_OE_O && SD_O == $past(d.rd_sh[7]);
    endproperty
    a_read_drive:
    assert property (p_read_drive) else $error("read data not driven after address");

    property p_oe_only_read;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        SD_OE_O |-> q.state == SCP_RDATA;
    endproperty
    a_oe_only_read:
    assert property (p_oe_only_read) else $error("data line driven outside a read");

    property p_mrst_off;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !syn.clean[SYN_MRST_N] |=> !TXRX_EN_O && STANDBY_O;
    endproperty
    a_mrst_off:
    assert property (p_mrst_off) else $error("transceiver active in master reset");

    property p_standby_leaves;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(syn.clean[SYN_MRST_N]) |=> !STANDBY_O;
    endproperty
    a_standby_leaves:
    assert property (p_standby_leaves) else $error("standby held after master reset release");

    property p_re_hold;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(TXRX_EN_O) |-> $past(syn.clean[SYN_RE], 1) && $past(syn.clean[SYN_RE], 2);
    endproperty
    a_re_hold:
    assert property (p_re_hold) else $error("resumed before receive enable hold");

    property p_cfg_kept;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !syn.clean[SYN_MRST_N] && !sclk_rise |=> $stable(q.regs);
    endproperty
    a_cfg_kept:
    assert property (p_cfg_kept) else $error("master reset altered registers");

    property p_div4;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        TRX_CLK_EN_O && q.regs[IDX_TX_RX_CONTROL][DIV_SEL_BIT] && $stable(q.regs[IDX_TX_RX_CONTROL])
            |=> !TRX_CLK_EN_O [*3];
    endproperty
    a_div4:
    assert property (p_div4) else $error("divide-by-4 enable too frequent");

    property p_probe_qual;
        @(posedge CLK_SYS_I) disable iff (!NRST_I)
        !$stable(PROBE_DATA_O) |-> $fell(PROBE_CLK_O);
    endproperty
    a_probe_qual:
    assert property (p_probe_qual) else $error("probe data moved off the falling probe clock");

endmodule

// ===== logic/scp_sync.sv
// module: three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module scp_sync
    import scp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pin lanes
    scp_sync_if.sync pins
);

    typedef struct packed {
        logic [SYN_W-1:0] s1;
        logic [SYN_W-1:0] s2;
        logic [SYN_W-1:0] s3;
        logic [SYN_W-1:0] out;
    } scp_sync_t;

    scp_sync_t q, d;

    // a lane changes only once the second and third stages agree
    always_comb begin
        d = q;
        d.s1 = pins.raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < SYN_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.out[i] = q.s3[i];
            end
        end
    end

    // reset values keep select and master reset inactive
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q <= '{s1: SYN_RST, s2: SYN_RST, s3: SYN_RST, out: SYN_RST};
        end else begin
            q <= d;
        end
    end

    assign pins.clean = q.out;

endmodule

// ===== testbench/scp_ctrl_model.sv
// partner model: external controller driving the serial configuration port
`timescale 1ns/10ps
module scp_ctrl_model (
    // clock shared with the device
    input wire logic clk_i,
    // device side of the data line
    input wire logic sd_dev_i,
    input wire logic sd_oe_i,
    // controller pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic rw_o,
    output logic sd_line_o
);
    logic sd_q = 1'b0;
    logic rel_q = 1'b0;

    // resolved line; a released line shows the inverse of the device bit, so a missing enable is caught
    assign sd_line_o = sd_oe_i ? sd_dev_i : (rel_q ? ~sd_dev_i : sd_q);

    // serial clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        rw_o = 1'b0;
    end

    // twelve system cycles per half keep the serial clock under its rate limit
    task automatic half();
        repeat (12) @(posedge clk_i);
        #1;
    endtask

    // address byte then data byte msb first; fewer bits abandon the frame
    task automatic xfer(input logic sel, input logic rd, input logic [7:0] adr, input logic [7:0] wd,
                        input int nbits, output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {adr, wd};
        rdat = 8'h00;
        cs_n_o = ~sel;
        rw_o = rd;
        for (int i = 0; i < nbits; i++) begin
            if (i >= 8 && rd) begin
                rel_q = 1'b1;
            end else begin
                sd_q = sh[15 - i];
            end
            half();
            // sample just before the rise, bit launched a full clock period earlier
            if (i >= 8 && rd) begin
                rdat[15 - i] = sd_line_o;
            end
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        rel_q = 1'b0;
        half();
        cs_n_o = 1'b1;
        half();
    endtask
endmodule

// ===== testbench/scp_serial_regs_test.sv
// testbench: serial configuration port and its register map
`timescale 1ns/10ps
module scp_serial_regs_test;
    import scp_pkg::*;

    localparam logic [7:0] PV = 8'hc3; // identity byte, value arbitrary
    logic clk = 1'b0;
    logic nrst, sclk, cs_n, rw, sd_line, sd_dev, sd_oe, mrst_n, rx_en;
    logic standby, txrx_en, trx_clk_en, probe_clk;
    logic [7:0] probe_data;
    logic [REG_NUM*DATA_W-1:0] cfg;
    logic [7:0] rx_in [4] = '{8'h9a, 8'h3b, 8'hc4, 8'h51};
    logic [7:0] shadow [32];
    int bad_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    scp_serial_regs #(.PART_VERSION(PV)) i_scp_serial_regs (
        .CLK_SYS_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .CS_N_I(cs_n), .RW_I(rw),
        .SD_I(sd_line), .SD_O(sd_dev), .SD_OE_O(sd_oe), .MRST_N_I(mrst_n),
        .RECEIVE_ENABLE_I(rx_en), .STANDBY_O(standby), .TXRX_EN_O(txrx_en),
        .TRX_CLK_EN_O(trx_clk_en), .RX_STATUS_I(rx_in[0]), .RX_SERVICE_I(rx_in[1]),
        .RX_LEN_HIGH_I(rx_in[2]), .RX_LEN_LOW_I(rx_in[3]), .CFG_REGS_O(cfg),
        .PROBE_CLK_O(probe_clk), .PROBE_DATA_O(probe_data)
    );

    scp_ctrl_model i_scp_ctrl_model (
        .clk_i(clk), .sd_dev_i(sd_dev), .sd_oe_i(sd_oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .rw_o(rw), .sd_line_o(sd_line)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic ro(input logic [4:0] i);
        return i == 5'd0 || (i >= 5'd24 && i <= 5'd27) || i == 5'd29;
    endfunction

    // factory test slots get their fixed loads, the rest a unique pattern
    function automatic logic [7:0] pat(input int i);
        return i == 30 ? 8'h00 : i == 31 ? 8'h02 : 8'(i * 8 + 2);
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a[7]) return 8'h00;
        if (a[6:2] == 5'd0) return PV;
        if (a[6:2] >= 5'd24 && a[6:2] <= 5'd27) return rx_in[a[3:2]];
        if (a[6:2] == 5'd29) return shadow[shadow[28][4:0]];
        return shadow[a[6:2]];
    endfunction

    // shadow follows only writes the device must accept
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_scp_ctrl_model.xfer(1'b1, 1'b0, a, d, 16, r);
        if (!a[7] && !ro(a[6:2])) shadow[a[6:2]] = d;
    endtask

    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] r;
        i_scp_ctrl_model.xfer(1'b1, 1'b1, a, 8'h00, 16, r);
        chk(r, exp_rd(a), "read");
    endtask

    task automatic cfg_chk();
        for (int i = 0; i < 32; i++) chk(cfg[8*i +: 8], ro(5'(i)) ? 8'h00 : shadow[i], "stored");
    endtask

    // strobes and probe clock toggles over forty cycles
    task automatic count(input int exp_n);
        int n;
        int t;
        logic pc;
        n = 0;
        t = 0;
        pc = probe_clk;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (trx_clk_en === 1'b1) n++;
            if (probe_clk !== pc) t++;
            pc = probe_clk;
        end
        chk(8'(n), 8'(exp_n), "strobes");
        chk(8'(t), 8'(exp_n), "probe clock");
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("BAD %0t run did not finish", $time);
        print_verdict();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        nrst = 1'b0;
        mrst_n = 1'b1;
        rx_en = 1'b1;
        wait_cyc(8);
        nrst = 1'b1;
        wait_cyc(8);
        for (int i = 0; i < 32; i++) wr(8'(i * 4), pat(i));
        cfg_chk();
        wr(8'h0b, 8'h4d);
        wr(8'h80, 8'hff);
        i_scp_ctrl_model.xfer(1'b1, 1'b0, 8'h14, 8'hee, 12, shadow[0]);
        i_scp_ctrl_model.xfer(1'b0, 1'b0, 8'h14, 8'hee, 16, shadow[0]);
        cfg_chk();
        count(10);
        wr(8'h08, 8'h12);
        count(20);
        chk(probe_data, 8'h12, "probe bus");
        for (int i = 0; i < 32; i++) rd_chk(8'(i * 4));
        rd_chk(8'h63);
        rd_chk(8'h80);
        chk({7'h00, txrx_en}, 8'h01, "active after traffic");
        mrst_n = 1'b0;
        wait_cyc(12);
        chk({6'h00, standby, txrx_en}, 8'h02, "master reset");
        rd_chk(8'h14);
        cfg_chk();
        rx_en = 1'b0;
        mrst_n = 1'b1;
        wait_cyc(12);
        chk({6'h00, standby, txrx_en}, 8'h00, "no receive enable");
        rx_en = 1'b1;
        wait_cyc(12);
        chk({6'h00, standby, txrx_en}, 8'h01, "resumed");
        print_verdict();
    end
endmodule
